// >>> rtl/cmph_pkg.sv
package cmph_pkg;

  // ==========================================================
  // Controller modes
  typedef enum logic [1:0] {
    CMPH_MODE_PROG,
    CMPH_MODE_RUN,
    CMPH_MODE_TEST,
    CMPH_MODE_SUSPEND
  } cmph_mode_t;

  // ==========================================================
  // Clock file field widths
  localparam int unsigned YEAR_W = 7;
  localparam int unsigned MON_W  = 4;
  localparam int unsigned DAY_W  = 5;
  localparam int unsigned HOUR_W = 5;
  localparam int unsigned MIN_W  = 6;
  localparam int unsigned SEC_W  = 6;
  localparam int unsigned DOW_W  = 3;

  // ==========================================================
  // Calendar limits
  localparam logic [MON_W-1:0]  MON_MAX  = 4'hc;
  localparam logic [HOUR_W-1:0] HOUR_MAX = 5'h17;
  localparam logic [MIN_W-1:0]  MIN_MAX  = 6'h3b;
  localparam logic [SEC_W-1:0]  SEC_MAX  = 6'h3b;
  localparam logic [DOW_W-1:0]  DOW_MAX  = 3'h6;
  localparam logic [DAY_W-1:0]  DAY_FEB_LEAP = 5'h1d;
  localparam logic [DAY_W-1:0]  DAY_FEB  = 5'h1c;
  localparam logic [DAY_W-1:0]  DAY_SHORT = 5'h1e;
  localparam logic [DAY_W-1:0]  DAY_LONG  = 5'h1f;
  localparam logic [MON_W-1:0]  MON_FEB  = 4'h2;

  // ==========================================================
  // Reset values and timing
  localparam logic [YEAR_W-1:0] YEAR_RST = 7'h00;
  localparam logic [MON_W-1:0]  MON_RST  = 4'h0;
  localparam logic [DAY_W-1:0]  DAY_RST  = 5'h00;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_HZ     = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;

endpackage

// >>> rtl/cmph_date_check.sv
`timescale 1ns/10ps
module cmph_date_check (
  // Candidate date and time
  input  wire logic [6:0] year,
  input  wire logic [3:0] month,
  input  wire logic [4:0] day,
  input  wire logic [4:0] hour,
  input  wire logic [5:0] minute,
  input  wire logic [5:0] second,
  input  wire logic [2:0] dow,
  // Verdict
  output logic            valid
);

  // ==========================================================
  // Days in month, leap year every fourth year of the century
  logic [4:0] dmax;
  always_comb begin
    case (month)
      4'h4, 4'h6, 4'h9, 4'hb: dmax = cmph_pkg::DAY_SHORT;
      cmph_pkg::MON_FEB: dmax = (year[1:0] == 2'h0) ?
        cmph_pkg::DAY_FEB_LEAP : cmph_pkg::DAY_FEB;
      default: dmax = cmph_pkg::DAY_LONG;
    endcase
  end

  // Any one bad field spoils the whole write
  always_comb begin
    valid = (month != 4'h0) && (month <= cmph_pkg::MON_MAX) &&
            (day != 5'h00) && (day <= dmax) &&
            (hour <= cmph_pkg::HOUR_MAX) &&
            (minute <= cmph_pkg::MIN_MAX) &&
            (second <= cmph_pkg::SEC_MAX) &&
            (dow <= cmph_pkg::DOW_MAX) &&
            (year <= 7'h63);
  end

endmodule

// >>> rtl/cmph_tick.sv
`timescale 1ns/10ps
module cmph_tick #(
  parameter int unsigned CYCLES = cmph_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Restart and pulse
  input  wire logic clr,
  output logic      tick
);

  // ==========================================================
  // One-second enable divider
  logic [31:0] cnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (clr) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule

// >>> rtl/cmph_top.sv
// Overview of operation
// - Probe for the clock module on entering run or test from a non-executing state; the power-up probe sees the synchronisers at reset, so finds none.
// - When found, copy module date, time and status into the clock file.
// - Module inserted during run or test stays ignored until non-executing.
// - Removal in run mode is detected by the end of the current scan.
// - Removal in run mode clears every date and time field of the clock file to zero.
// - Valid writes from a programmer or peer take effect at once while a module is attached.
// - Invalid writes are refused and the clock keeps its contents.
// - Battery-low flag reads 1 while the module battery is low.
// - Battery-low flag reads 0 when battery is good or no module.
// - Clock keeps counting normally while the battery is low.
// - Powering off with a low battery loses the clock contents.
`timescale 1ns/10ps
module cmph_top #(
  parameter int unsigned TICK_CYCLES = cmph_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Controller state
  input  wire cmph_pkg::cmph_mode_t  mode,
  input  wire logic                  fault,
  input  wire logic                  scan_end,
  // Module pins
  input  wire logic                  mod_present_n,
  input  wire logic                  mod_batt_low,
  input  wire logic                  mod_lost,
  input  wire logic [6:0]            mod_year,
  input  wire logic [3:0]            mod_month,
  input  wire logic [4:0]            mod_day,
  input  wire logic [4:0]            mod_hour,
  input  wire logic [5:0]            mod_minute,
  input  wire logic [5:0]            mod_second,
  input  wire logic [2:0]            mod_dow,
  // Date and time write request
  input  wire logic                  wr_req,
  input  wire logic [6:0]            wr_year,
  input  wire logic [3:0]            wr_month,
  input  wire logic [4:0]            wr_day,
  input  wire logic [4:0]            wr_hour,
  input  wire logic [5:0]            wr_minute,
  input  wire logic [5:0]            wr_second,
  input  wire logic [2:0]            wr_dow,
  input  wire logic                  clk_disable,
  output logic                       wr_ack,
  output logic                       wr_nak,
  // Clock function file
  output logic [6:0]                 year_q,
  output logic [3:0]                 month_q,
  output logic [4:0]                 day_q,
  output logic [4:0]                 hour_q,
  output logic [5:0]                 minute_q,
  output logic [5:0]                 second_q,
  output logic [2:0]                 dow_q,
  output logic                       battery_low_flag,
  output logic                       clk_enabled_q,
  output logic                       attached_q
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {~mod_present_n, mod_batt_low, mod_lost};
      s2_q <= s1_q;
    end
  end
  logic present;
  logic batt_low;
  logic lost;
  assign present  = s2_q[2];
  assign batt_low = s2_q[1];
  assign lost     = s2_q[0];

  // ==========================================================
  // Execution state and probe request
  logic executing;
  logic exec_q;
  logic boot_q;
  logic gone_q;
  assign executing = ((mode == cmph_pkg::CMPH_MODE_RUN) ||
                      (mode == cmph_pkg::CMPH_MODE_TEST)) && !fault;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      exec_q <= 1'b0;
      boot_q <= 1'b1;
    end else begin
      exec_q <= executing;
      boot_q <= 1'b0;
    end
  end

  logic probe;
  // Probe at power-up, and whenever executing rises: entry into run or test from a non-executing state, or fault clearing
  assign probe = boot_q || (executing && !exec_q);

  // ==========================================================
  // Attachment tracking
  // While executing, a newly inserted module is not looked at, so a
  // card pushed in mid-run cannot disturb the running program.
  logic pend_rm_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      attached_q <= 1'b0;
      pend_rm_q  <= 1'b0;
    end else if (probe || !executing) begin
      attached_q <= present;
      pend_rm_q  <= 1'b0;
    end else if (attached_q && !present) begin
      pend_rm_q  <= 1'b1;
      if (scan_end || pend_rm_q) begin
        attached_q <= 1'b0;
      end
    end else begin
      pend_rm_q <= 1'b0;
    end
  end
  // Removal is acted on at the latest at the end of the current scan;
  // pend_rm_q clears it one cycle after the removal is seen, even without scan_end.
  assign gone_q = attached_q && !present && executing &&
                  (scan_end || pend_rm_q);

  // ==========================================================
  // Write validation
  logic wr_ok;
  cmph_date_check u_check (
    .year   (wr_year),
    .month  (wr_month),
    .day    (wr_day),
    .hour   (wr_hour),
    .minute (wr_minute),
    .second (wr_second),
    .dow    (wr_dow),
    .valid  (wr_ok)
  );

  logic tick;
  cmph_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (wr_req && wr_ok),
    .tick    (tick)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ack <= 1'b0;
      wr_nak <= 1'b0;
    end else begin
      wr_ack <= wr_req && wr_ok && attached_q;
      wr_nak <= wr_req && !(wr_ok && attached_q);
    end
  end

  // ==========================================================
  // Calendar roll-over
  logic [4:0] dmax;
  always_comb begin
    case (month_q)
      4'h4, 4'h6, 4'h9, 4'hb: dmax = cmph_pkg::DAY_SHORT;
      cmph_pkg::MON_FEB: dmax = (year_q[1:0] == 2'h0) ?
        cmph_pkg::DAY_FEB_LEAP : cmph_pkg::DAY_FEB;
      default: dmax = cmph_pkg::DAY_LONG;
    endcase
  end

  // ==========================================================
  // Clock function file
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Contents behind a low battery are not trusted across power loss
      year_q   <= cmph_pkg::YEAR_RST;
      month_q  <= cmph_pkg::MON_RST;
      day_q    <= cmph_pkg::DAY_RST;
      hour_q   <= 5'h00;
      minute_q <= 6'h00;
      second_q <= 6'h00;
      dow_q    <= 3'h0;
    end else if (gone_q || (probe && !present) ||
                 (!executing && !present)) begin
      year_q   <= 7'h00;
      month_q  <= 4'h0;
      day_q    <= 5'h00;
      hour_q   <= 5'h00;
      minute_q <= 6'h00;
      second_q <= 6'h00;
      dow_q    <= 3'h0;
    end else if ((probe || (!executing && !attached_q)) && present) begin
      // Lost flag is a pin, so only its synchronised copy is read
      year_q   <= lost ? 7'h00 : mod_year;
      month_q  <= lost ? 4'h0 : mod_month;
      day_q    <= lost ? 5'h00 : mod_day;
      hour_q   <= lost ? 5'h00 : mod_hour;
      minute_q <= lost ? 6'h00 : mod_minute;
      second_q <= lost ? 6'h00 : mod_second;
      dow_q    <= lost ? 3'h0 : mod_dow;
    end else if (wr_req && wr_ok && attached_q) begin
      year_q   <= wr_year;
      month_q  <= wr_month;
      day_q    <= wr_day;
      hour_q   <= wr_hour;
      minute_q <= wr_minute;
      second_q <= wr_second;
      dow_q    <= wr_dow;
    end else if (tick && attached_q && clk_enabled_q) begin
      // Battery state plays no part in counting
      if (second_q != cmph_pkg::SEC_MAX) begin
        second_q <= second_q + 6'h01;
      end else begin
        second_q <= 6'h00;
        if (minute_q != cmph_pkg::MIN_MAX) begin
          minute_q <= minute_q + 6'h01;
        end else begin
          minute_q <= 6'h00;
          if (hour_q != cmph_pkg::HOUR_MAX) begin
            hour_q <= hour_q + 5'h01;
          end else begin
            hour_q <= 5'h00;
            dow_q  <= (dow_q == cmph_pkg::DOW_MAX) ? 3'h0 : dow_q + 3'h1;
            if (day_q < dmax) begin
              day_q <= day_q + 5'h01;
            end else begin
              day_q <= 5'h01;
              if (month_q != cmph_pkg::MON_MAX) begin
                month_q <= month_q + 4'h1;
              end else begin
                month_q <= 4'h1;
                year_q  <= (year_q == 7'h63) ? 7'h00 : year_q + 7'h01;
              end
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Status bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      battery_low_flag <= 1'b0;
      clk_enabled_q    <= 1'b1;
    end else begin
      // No module attached always reads as a good battery
      battery_low_flag <= batt_low && present &&
                          (attached_q || !executing);
      // Storage mode: a disabled clock stops counting to save battery
      if (clk_disable) begin
        clk_enabled_q <= 1'b0;
      end else if (wr_req && wr_ok && attached_q) begin
        clk_enabled_q <= 1'b1;
      end
    end
  end

endmodule

// >>> bench/cmph_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Checker on the top ports
module cmph_sva (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // Controller and module
  input wire cmph_pkg::cmph_mode_t mode,
  input wire logic                 fault,
  input wire logic                 scan_end,
  input wire logic                 mod_present_n,
  input wire logic                 mod_batt_low,
  // Write handshake and file
  input wire logic                 wr_req,
  input wire logic                 wr_ack,
  input wire logic                 wr_nak,
  input wire logic [6:0]           year_q,
  input wire logic [3:0]           month_q,
  input wire logic [4:0]           day_q,
  input wire logic [4:0]           hour_q,
  input wire logic                 battery_low_flag,
  input wire logic                 attached_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic ex;
  logic gone;
  assign ex = (mode == cmph_pkg::CMPH_MODE_RUN
               || mode == cmph_pkg::CMPH_MODE_TEST) && !fault;
  assign gone = mode == cmph_pkg::CMPH_MODE_RUN && mod_present_n
                && attached_q;
  // Three cycles lets the pin synchroniser settle first
  sequence s_gone;
    gone[*3] ##0 scan_end;
  endsequence
  sequence s_idle;
    (ex && !attached_q)[*2] ##1 ex;
  endsequence
  a_answer_cause: assert property (
    (wr_ack || wr_nak) |-> $past(wr_req)) else $error("answer unasked");
  a_ack_nak_excl: assert property (
    !(wr_ack && wr_nak)) else $error("ack and nak together");
  a_nak_holds: assert property (
    wr_nak |-> $stable({year_q, month_q, day_q}))
    else $error("refused write changed the file");
  a_remove_bound: assert property (
    s_gone |-> ##[1:3] !attached_q) else $error("removal missed");
  a_remove_zero: assert property (
    $fell(attached_q) && mode == cmph_pkg::CMPH_MODE_RUN
    |-> {year_q, month_q, day_q, hour_q} == 21'h0)
    else $error("file not cleared on removal");
  a_batt_set: assert property (
    (attached_q && !mod_present_n && mod_batt_low)[*4]
    |-> battery_low_flag) else $error("battery flag not set");
  a_batt_clear: assert property (
    (!attached_q)[*3] |-> !battery_low_flag)
    else $error("battery flag set without module");
  a_insert_ignored: assert property (
    s_idle |-> !attached_q) else $error("insertion seen while running");
endmodule

bind cmph_top cmph_sva i_cmph_sva (
  .clk(clk), .sys_rst(sys_rst), .mode(mode), .fault(fault),
  .scan_end(scan_end), .mod_present_n(mod_present_n),
  .mod_batt_low(mod_batt_low), .wr_req(wr_req), .wr_ack(wr_ack),
  .wr_nak(wr_nak), .year_q(year_q), .month_q(month_q), .day_q(day_q),
  .hour_q(hour_q), .battery_low_flag(battery_low_flag),
  .attached_q(attached_q));

// >>> bench/cmph_rtc_model.sv
`timescale 1ns/10ps
// ==========================================================
// Plug-in clock module
module cmph_rtc_model #(
  parameter logic [35:0] DATE = 36'h0
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  sys_rst,
  // Scenario controls
  input wire logic  plugged,
  input wire logic  batt,
  // Module pins
  output logic        mod_present_n,
  output logic        mod_batt_low,
  output logic        mod_lost,
  output logic [35:0] mod_date
);
  logic [35:0] junk_q;
  // Empty socket battery, lost and date lines float, so never show a held value
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) junk_q <= '0;
    else junk_q <= ~junk_q;
  end
  assign mod_present_n = !plugged;
  assign mod_batt_low = plugged ? batt : junk_q[0];
  assign mod_lost = plugged ? 1'b0 : junk_q[1];
  assign mod_date = plugged ? DATE : junk_q;
endmodule

// >>> bench/clock_module_presence_handler_test.sv
`timescale 1ns/10ps
// ==========================================================
// Bench
module clock_module_presence_handler_test;
  localparam logic [35:0] DT = {7'h18, 4'h3, 5'h0f, 5'h0a, 21'h3c0a};
  localparam logic [35:0] W1 = {7'h19, 4'hc, 5'h1f, 5'h17, 15'h6};
  logic clk = 0, sys_rst = 1, fault = 0, scan_end = 0, wr_req = 0;
  logic clk_disable = 0, plugged = 1, batt = 0;
  cmph_pkg::cmph_mode_t mode = cmph_pkg::CMPH_MODE_PROG;
  logic [35:0] wv = '0;
  wire [35:0] md, fq;
  wire pn, bl, ml, ack, nak, blf, en, att;
  int fail_count = 0, checked = 0;
  cmph_rtc_model #(.DATE(DT)) i_cmph_rtc_model (.clk(clk),
    .sys_rst(sys_rst), .plugged(plugged), .batt(batt),
    .mod_present_n(pn), .mod_batt_low(bl), .mod_lost(ml), .mod_date(md));
  cmph_top #(.TICK_CYCLES(4)) i_cmph_top (.clk(clk), .sys_rst(sys_rst),
    .mode(mode), .fault(fault), .scan_end(scan_end), .mod_present_n(pn),
    .mod_batt_low(bl), .mod_lost(ml), .mod_year(md[35:29]),
    .mod_month(md[28:25]), .mod_day(md[24:20]), .mod_hour(md[19:15]),
    .mod_minute(md[14:9]), .mod_second(md[8:3]), .mod_dow(md[2:0]),
    .wr_req(wr_req), .wr_year(wv[35:29]), .wr_month(wv[28:25]),
    .wr_day(wv[24:20]), .wr_hour(wv[19:15]), .wr_minute(wv[14:9]),
    .wr_second(wv[8:3]), .wr_dow(wv[2:0]), .clk_disable(clk_disable),
    .wr_ack(ack), .wr_nak(nak), .year_q(fq[35:29]),
    .month_q(fq[28:25]), .day_q(fq[24:20]), .hour_q(fq[19:15]),
    .minute_q(fq[14:9]), .second_q(fq[8:3]), .dow_q(fq[2:0]),
    .battery_low_flag(blf), .clk_enabled_q(en), .attached_q(att));
  initial begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic [35:0] d(int y, mo, dy, h, mi, s, w);
    return {y[6:0], mo[3:0], dy[4:0], h[4:0], mi[5:0], s[5:0], w[2:0]};
  endfunction
  task automatic chk(input string nm, input logic [35:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Answer is registered, so it is read one cycle after the request
  task automatic wr(input logic [35:0] v, input logic ok);
    @(negedge clk);
    wv = v;
    wr_req = 1;
    @(negedge clk);
    wr_req = 0;
    chk("ack", ok, ack);
    chk("nak", !ok, nak);
  endtask
  task automatic nakw(input logic [35:0] v);
    wr(v, 0);
    chk("held", W1[35:15], fq[35:15]);
  endtask
  task automatic t_boot;
    cyc(6);
    chk("attached", 1, att);
    chk("copied", DT[35:15], fq[35:15]);
    chk("batt", 0, blf);
  endtask
  task automatic t_write;
    mode = cmph_pkg::CMPH_MODE_RUN;
    cyc(3);
    chk("attached", 1, att);
    wr(W1, 1);
    chk("file", W1, fq);
    nakw(d(23, 2, 29, 1, 0, 0, 0));
    nakw(d(24, 4, 31, 1, 0, 0, 0));
    nakw(d(24, 13, 1, 1, 0, 0, 0));
    nakw(d(24, 0, 1, 1, 0, 0, 0));
    nakw(d(24, 1, 0, 1, 0, 0, 0));
    nakw(d(100, 1, 1, 1, 0, 0, 0));
    nakw(d(24, 1, 1, 24, 0, 0, 0));
    nakw(d(24, 1, 1, 1, 60, 0, 0));
    nakw(d(24, 1, 1, 1, 0, 60, 0));
    nakw(d(24, 1, 1, 1, 0, 0, 7));
    wr(d(24, 2, 29, 0, 59, 59, 6), 1);
    chk("leap", d(24, 2, 29, 0, 59, 59, 6), fq);
  endtask
  task automatic t_batt;
    logic [5:0] s0;
    batt = 1;
    cyc(5);
    chk("batt", 1, blf);
    s0 = fq[8:3];
    cyc(9);
    chk("ticking", 1, fq[8:3] !== s0);
  endtask
  task automatic t_remove;
    clk_disable = 1;
    cyc(1);
    clk_disable = 0;
    chk("enabled", 0, en);
    plugged = 0;
    cyc(3);
    scan_end = 1;
    cyc(1);
    scan_end = 0;
    cyc(3);
    chk("attached", 0, att);
    chk("cleared", 0, fq);
    chk("batt", 0, blf);
  endtask
  task automatic t_insert;
    plugged = 1;
    cyc(8);
    chk("ignored", 0, att);
    fault = 1;
    cyc(6);
    chk("attached", 1, att);
    chk("copied", DT[35:15], fq[35:15]);
    chk("batt", 1, blf);
    fault = 0;
    mode = cmph_pkg::CMPH_MODE_TEST;
    cyc(2);
    chk("test probe", 1, att);
  endtask
  task automatic wrap_up;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(25ns * 4000);
    fail_count++;
    wrap_up;
  end
  initial begin
    cyc(4);
    sys_rst = 0;
    t_boot;
    t_write;
    t_batt;
    t_remove;
    t_insert;
    wrap_up;
  end
endmodule
